// File: hbd_device.sv
/*
 Device end: IN/IN decode, fixed-frequency current chopping with blanking,
 per-bridge overcurrent shutdown with retry, thermal cutout, sleep and lockout.
 Assumes comparator, overcurrent and temperature flags arrive synchronous to ref_clk.
*/
`timescale 1ns/1ns
`include "hbd_map.svh"
module hbd_device #(
   parameter int RETRY_CYC = `HBD_RETRY_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   hbd_if.device pins,
   input wire logic [1:0] chop_trip,
   input wire logic [3:0] overcurrent_guard_a,
   input wire logic [3:0] overcurrent_guard_b,
   input wire logic thermal_cutout,
   input wire logic supply_lockout,
   output logic [3:0] fet_gate_a,
   output logic [3:0] fet_gate_b,
   output logic charge_pump_en,
   output logic [1:0] bridge_shutdown
);
   import hbd_pkg::*;

   localparam logic [`HBD_CNT_W-1:0] PWM_LAST = `HBD_CNT_W'(`HBD_PWM_CYC - 1);
   localparam logic [`HBD_CNT_W-1:0] BLANK_LAST = `HBD_CNT_W'(`HBD_BLANK_CYC - 1);
   localparam logic [`HBD_CNT_W-1:0] DEG_LAST = `HBD_CNT_W'(`HBD_DEGLITCH_CYC - 1);
   localparam logic [`HBD_CNT_W-1:0] RETRY_LAST = `HBD_CNT_W'(RETRY_CYC - 1);

   // Sleep and lockout both hold the counters, chop flags and overcurrent state in reset
   logic lrst;
   assign lrst = rst || !pins.low_power_request_n || supply_lockout;
   assign charge_pump_en = !lrst;

   // Fixed-frequency period counter shared by both bridges
   logic [`HBD_CNT_W-1:0] pwm_cnt_q;
   logic period_start;
   assign period_start = (pwm_cnt_q == PWM_LAST);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pwm_cnt_q <= '0;
      end else if (lrst) begin
         pwm_cnt_q <= '0;
      end else if (period_start) begin
         pwm_cnt_q <= '0;
      end else begin
         pwm_cnt_q <= pwm_cnt_q + `HBD_CNT_W'(1);
      end
   end

   logic [1:0] oc_fault;
   logic [3:0] gate [2];
   logic [3:0] ocg [2];
   assign ocg[0] = overcurrent_guard_a;
   assign ocg[1] = overcurrent_guard_b;
   assign fet_gate_a = gate[0];
   assign fet_gate_b = gate[1];

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_br
         logic in1, in2, drive, chopped_q, oc_any;
         logic [`HBD_CNT_W-1:0] blank_q, deg_q, retry_q;
         hbd_oc_state_t oc_q;
         logic [3:0] g_d;
         logic [3:0] g_q;
         // Inputs are ignored by forcing them low while asleep
         assign in1 = pins.bridge_input_one[gi] && !lrst;
         assign in2 = pins.bridge_input_two[gi] && !lrst;
         assign drive = in1 ^ in2;
         assign oc_any = |ocg[gi];

         // Blanking restarts whenever drive starts or a period begins while chopped
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               blank_q <= '0;
            end else if (lrst || !drive) begin
               blank_q <= '0;
            end else if (period_start && chopped_q) begin
               blank_q <= '0;
            end else if (blank_q != BLANK_LAST) begin
               blank_q <= blank_q + `HBD_CNT_W'(1);
            end
         end

         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               chopped_q <= 1'b0;
            end else if (lrst || !drive || period_start) begin
               chopped_q <= 1'b0;
            end else if (chop_trip[gi] && blank_q == BLANK_LAST) begin
               chopped_q <= 1'b1;
            end
         end

         // Overcurrent deglitch and retry
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               oc_q <= HBD_RUN;
               deg_q <= '0;
               retry_q <= '0;
            end else if (lrst) begin
               oc_q <= HBD_RUN;
               deg_q <= '0;
               retry_q <= '0;
            end else begin
               case (oc_q)
                  HBD_RUN: begin
                     if (!oc_any) begin
                        deg_q <= '0;
                     end else if (deg_q == DEG_LAST) begin
                        oc_q <= HBD_OC_RETRY;
                        retry_q <= '0;
                        deg_q <= '0;
                     end else begin
                        deg_q <= deg_q + `HBD_CNT_W'(1);
                     end
                  end
                  HBD_OC_RETRY: begin
                     if (retry_q == RETRY_LAST) begin
                        oc_q <= HBD_RUN;
                     end else begin
                        retry_q <= retry_q + `HBD_CNT_W'(1);
                     end
                  end
                  default: begin
                     oc_q <= HBD_RUN;
                  end
               endcase
            end
         end
         assign oc_fault[gi] = (oc_q == HBD_OC_RETRY);

         // Gate order: high side 1, low side 1, high side 2, low side 2
         always_comb begin
            g_d = 4'h0;
            if (in1 && !in2) begin
               g_d[`HBD_FET_HS1] = 1'b1;
               g_d[`HBD_FET_LS2] = 1'b1;
            end else if (!in1 && in2) begin
               g_d[`HBD_FET_HS2] = 1'b1;
               g_d[`HBD_FET_LS1] = 1'b1;
            end else if (in1 && in2) begin
               g_d[`HBD_FET_LS1] = 1'b1;
               g_d[`HBD_FET_LS2] = 1'b1;
            end
            // A stale chop flag must not override coast for the cycle it takes to clear
            if (chopped_q && drive) begin
               g_d = 4'h0;
               g_d[`HBD_FET_LS1] = 1'b1;
               g_d[`HBD_FET_LS2] = 1'b1;
            end
            if (oc_fault[gi] || thermal_cutout || lrst) begin
               g_d = 4'h0;
            end
         end

         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               g_q <= 4'h0;
            end else begin
               g_q <= g_d;
            end
         end
         assign gate[gi] = g_q;
      end
   endgenerate

   logic fault_q;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= (|oc_fault) || supply_lockout;
      end
   end
   assign pins.fault_out_o = 1'b0;
   assign pins.fault_out_oe = fault_q;
   assign bridge_shutdown = oc_fault;
endmodule

// File: hbd_map.svh
/*
 Constants for the dual H-bridge drive control: timing counts at 125 MHz.
 Assumes the includer runs on one 8 ns clock.
*/
`ifndef HBD_MAP_SVH
`define HBD_MAP_SVH
`define HBD_CLK_MHZ 125
`define HBD_BLANK_NS 3100
`define HBD_BLANK_CYC ((`HBD_BLANK_NS * `HBD_CLK_MHZ + 999) / 1000)
`define HBD_DEGLITCH_NS 180
`define HBD_DEGLITCH_CYC ((`HBD_DEGLITCH_NS * `HBD_CLK_MHZ + 999) / 1000)
`define HBD_RETRY_US 1500
`define HBD_RETRY_CYC (`HBD_RETRY_US * `HBD_CLK_MHZ)
`define HBD_PWM_KHZ 50
`define HBD_PWM_CYC ((`HBD_CLK_MHZ * 1000) / `HBD_PWM_KHZ)
`define HBD_WAKE_US 1
`define HBD_WAKE_CYC (`HBD_WAKE_US * `HBD_CLK_MHZ)
`define HBD_CNT_W 18
`define HBD_FET_HS1 0
`define HBD_FET_LS1 1
`define HBD_FET_HS2 2
`define HBD_FET_LS2 3
`endif

// File: hbd_pkg.sv
/*
 Types shared by both ends of the dual H-bridge link.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package hbd_pkg;
   typedef enum logic [3:0] {
      HBD_RUN = 4'h1,
      HBD_OC_TRIP = 4'h2,
      HBD_OC_RETRY = 4'h4,
      HBD_SPARE = 4'h8
   } hbd_oc_state_t;
   typedef enum logic [2:0] {
      HBD_CMD_COAST = 3'h0,
      HBD_CMD_FWD = 3'h1,
      HBD_CMD_REV = 3'h2,
      HBD_CMD_BRAKE = 3'h3,
      HBD_CMD_FWD_FAST = 3'h4,
      HBD_CMD_FWD_SLOW = 3'h5,
      HBD_CMD_REV_FAST = 3'h6,
      HBD_CMD_REV_SLOW = 3'h7
   } hbd_cmd_t;
endpackage

// File: hbd_if.sv
/*
 Pin-level link between the host controller and the bridge device.
 Assumes both ends run on ref_clk; the fault line is open drain, pulled high here.
*/
`timescale 1ns/1ns
interface hbd_if;
   logic low_power_request_n;
   logic [1:0] bridge_input_one;
   logic [1:0] bridge_input_two;
   logic fault_out_o;
   logic fault_out_oe;
   logic fault_flag_out_n;
   assign fault_flag_out_n = !(fault_out_oe && !fault_out_o);
   modport device (
      input low_power_request_n,
      input bridge_input_one,
      input bridge_input_two,
      output fault_out_o,
      output fault_out_oe
   );
   modport host (
      output low_power_request_n,
      output bridge_input_one,
      output bridge_input_two,
      input fault_flag_out_n
   );
endinterface

// File: hbd_host.sv
/*
 Host end: turns a per-bridge command and duty into IN/IN pin levels,
 drives the sleep pin and reports fault and wake-up readiness.
 Assumes commands are synchronous to ref_clk.
*/
`timescale 1ns/1ns
`include "hbd_map.svh"
module hbd_host (
   input wire logic ref_clk,
   input wire logic rst,
   hbd_if.host pins,
   input wire logic sleep_req,
   input wire hbd_pkg::hbd_cmd_t cmd_a,
   input wire hbd_pkg::hbd_cmd_t cmd_b,
   input wire logic [7:0] duty_a,
   input wire logic [7:0] duty_b,
   output logic ready,
   output logic fault_seen
);
   import hbd_pkg::*;

   localparam logic [`HBD_CNT_W-1:0] WAKE_LAST = `HBD_CNT_W'(`HBD_WAKE_CYC - 1);

   logic [7:0] ramp_q;
   logic [`HBD_CNT_W-1:0] wake_q;
   logic sleep_q;
   logic [1:0] in1_q, in2_q;
   hbd_cmd_t cmd [2];
   logic [7:0] duty [2];
   assign cmd[0] = cmd_a;
   assign cmd[1] = cmd_b;
   assign duty[0] = duty_a;
   assign duty[1] = duty_b;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ramp_q <= 8'h00;
      end else begin
         ramp_q <= ramp_q + 8'h01;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sleep_q <= 1'b1;
      end else begin
         sleep_q <= sleep_req;
      end
   end

   // Wake-up delay after leaving sleep
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wake_q <= '0;
      end else if (sleep_q) begin
         wake_q <= '0;
      end else if (wake_q != WAKE_LAST) begin
         wake_q <= wake_q + `HBD_CNT_W'(1);
      end
   end
   assign ready = !sleep_q && (wake_q == WAKE_LAST);

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_br
         logic pwm_on;
         assign pwm_on = (ramp_q < duty[gi]);
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               in1_q[gi] <= 1'b0;
               in2_q[gi] <= 1'b0;
            end else if (!ready) begin
               in1_q[gi] <= 1'b0;
               in2_q[gi] <= 1'b0;
            end else begin
               case (cmd[gi])
                  HBD_CMD_COAST: begin
                     in1_q[gi] <= 1'b0;
                     in2_q[gi] <= 1'b0;
                  end
                  HBD_CMD_FWD: begin
                     in1_q[gi] <= 1'b1;
                     in2_q[gi] <= 1'b0;
                  end
                  HBD_CMD_REV: begin
                     in1_q[gi] <= 1'b0;
                     in2_q[gi] <= 1'b1;
                  end
                  HBD_CMD_BRAKE: begin
                     in1_q[gi] <= 1'b1;
                     in2_q[gi] <= 1'b1;
                  end
                  HBD_CMD_FWD_FAST: begin
                     in1_q[gi] <= pwm_on;
                     in2_q[gi] <= 1'b0;
                  end
                  HBD_CMD_FWD_SLOW: begin
                     in1_q[gi] <= 1'b1;
                     in2_q[gi] <= !pwm_on;
                  end
                  HBD_CMD_REV_FAST: begin
                     in1_q[gi] <= 1'b0;
                     in2_q[gi] <= pwm_on;
                  end
                  HBD_CMD_REV_SLOW: begin
                     in1_q[gi] <= !pwm_on;
                     in2_q[gi] <= 1'b1;
                  end
                  default: begin
                     in1_q[gi] <= 1'b0;
                     in2_q[gi] <= 1'b0;
                  end
               endcase
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fault_seen <= 1'b0;
      end else begin
         fault_seen <= !pins.fault_flag_out_n;
      end
   end

   assign pins.low_power_request_n = !sleep_q;
   assign pins.bridge_input_one = in1_q;
   assign pins.bridge_input_two = in2_q;
endmodule

// File: hbd_chk.sv
/*
 Assertions on the host-device pin link and on the gates of both bridges.
 Assumes one clock domain; instantiated beside the link interface.
*/
`timescale 1ns/1ns
module hbd_chk #(
   parameter int RETRY_CYC = 50
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic low_power_request_n,
   input wire logic [1:0] bridge_input_one,
   input wire logic [1:0] bridge_input_two,
   input wire logic fault_out_o,
   input wire logic fault_out_oe,
   input wire logic fault_flag_out_n,
   input wire logic [3:0] fet_gate_a,
   input wire logic [3:0] fet_gate_b,
   input wire logic [1:0] bridge_shutdown
);
   localparam logic [7:0] WAKE_MIN = 8'h7c;
   logic [7:0] wake_q;
   logic [31:0] retry_q;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // Cycles since the sleep pin went high
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wake_q <= 8'h00;
      end else if (!low_power_request_n) begin
         wake_q <= 8'h00;
      end else if (wake_q != 8'hff) begin
         wake_q <= wake_q + 8'h01;
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         retry_q <= 32'h0;
      end else begin
         retry_q <= bridge_shutdown[0] ? retry_q + 32'h1 : 32'h0;
      end
   end
   sequence oc_entry;
      $rose(bridge_shutdown[0]);
   endsequence
   sequence oc_exit;
      $fell(bridge_shutdown[0]) && !bridge_shutdown[1];
   endsequence
   chk_coast_all_off: assert property ($past(bridge_input_one[0] == 1'b0 && bridge_input_two[0] == 1'b0)
      |-> fet_gate_a == 4'h0) else $error("coast left a gate on");
   chk_fwd_gates: assert property ($past(bridge_input_one[0] && !bridge_input_two[0])
      |-> fet_gate_a inside {4'h0, 4'h9, 4'ha}) else $error("forward gates wrong");
   chk_brake_low_sides: assert property ($past(bridge_input_one[0] && bridge_input_two[0])
      |-> fet_gate_a inside {4'h0, 4'ha}) else $error("brake gates wrong");
   chk_other_bridge_fwd: assert property ($past(bridge_input_one[1] && !bridge_input_two[1])
      |-> fet_gate_b inside {4'h0, 4'h9, 4'ha}) else $error("bridge b forward gates wrong");
   chk_sleep_gates_off: assert property (!low_power_request_n |=> fet_gate_a == 4'h0 && fet_gate_b == 4'h0)
      else $error("gates on in sleep");
   chk_wake_inputs_low: assert property (wake_q < WAKE_MIN |-> bridge_input_one == 2'b00 && bridge_input_two == 2'b00)
      else $error("inputs driven before wake delay");
   chk_shutdown_fault_low: assert property (oc_entry |-> ##1 (fault_out_oe && !fault_out_o && !fault_flag_out_n))
      else $error("fault not pulled on shutdown");
   chk_shutdown_gates_off: assert property (bridge_shutdown[0] |=> fet_gate_a == 4'h0)
      else $error("gates on during retry");
   chk_retry_length: assert property ($fell(bridge_shutdown[0]) && low_power_request_n
      |-> retry_q >= RETRY_CYC - 1 && retry_q <= RETRY_CYC + 1) else $error("retry length wrong");
   chk_fault_release: assert property (oc_exit |-> ##1 !fault_out_oe)
      else $error("fault held after retry");
endmodule

// File: test_dual_hbridge_drive_control.sv
/*
 Self-checking bench: host and device ends joined by hbd_if, with checker.
 Assumes the retry count is shortened to 50 cycles.
*/
`timescale 1ns/1ns
module test_dual_hbridge_drive_control;
   import hbd_pkg::*;
   localparam int RETRY = 50;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic sleep_req = 1'b0;
   hbd_cmd_t cmd_a = HBD_CMD_COAST;
   hbd_cmd_t cmd_b = HBD_CMD_COAST;
   logic [7:0] duty_a = 8'h80;
   logic [7:0] duty_b = 8'h80;
   logic [1:0] chop_trip = 2'h0;
   logic [3:0] oc_a = 4'h0;
   logic [3:0] oc_b = 4'h0;
   logic hot = 1'b0;
   logic low_sup = 1'b0;
   logic [3:0] fet_gate_a, fet_gate_b;
   logic [1:0] bridge_shutdown;
   logic charge_pump_en, ready, fault_seen;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   hbd_if hbd_if_i ();
   hbd_device #(.RETRY_CYC(RETRY)) hbd_device_i (.ref_clk(ref_clk), .rst(rst), .pins(hbd_if_i.device),
      .chop_trip(chop_trip), .overcurrent_guard_a(oc_a), .overcurrent_guard_b(oc_b), .thermal_cutout(hot),
      .supply_lockout(low_sup), .fet_gate_a(fet_gate_a), .fet_gate_b(fet_gate_b),
      .charge_pump_en(charge_pump_en), .bridge_shutdown(bridge_shutdown));
   hbd_host hbd_host_i (.ref_clk(ref_clk), .rst(rst), .pins(hbd_if_i.host), .sleep_req(sleep_req),
      .cmd_a(cmd_a), .cmd_b(cmd_b), .duty_a(duty_a), .duty_b(duty_b), .ready(ready), .fault_seen(fault_seen));
   hbd_chk #(.RETRY_CYC(RETRY)) hbd_chk_i (.ref_clk(ref_clk), .rst(rst),
      .low_power_request_n(hbd_if_i.low_power_request_n), .bridge_input_one(hbd_if_i.bridge_input_one),
      .bridge_input_two(hbd_if_i.bridge_input_two), .fault_out_o(hbd_if_i.fault_out_o),
      .fault_out_oe(hbd_if_i.fault_out_oe), .fault_flag_out_n(hbd_if_i.fault_flag_out_n),
      .fet_gate_a(fet_gate_a), .fet_gate_b(fet_gate_b), .bridge_shutdown(bridge_shutdown));
   always #4 ref_clk = ~ref_clk;
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         $display("[ERR] %0t run timed out", $time);
         end_of_test();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic do_reset();
      @(posedge ref_clk);
      rst <= 1'b1;
      cyc(8);
      rst <= 1'b0;
   endtask
   task automatic t_wake();
      int n = 0;
      sleep_req <= 1'b0;
      while (ready !== 1'b1 && n < 300) begin
         cyc(1);
         n++;
      end
      check(n >= 124 && n <= 130, 1);
      check({hbd_if_i.low_power_request_n, charge_pump_en}, 2'h3);
      $display("wake test done");
   endtask
   task automatic t_modes();
      logic [3:0] on_v [8] = '{4'h0, 4'h9, 4'h6, 4'ha, 4'h9, 4'h9, 4'h6, 4'h6};
      logic [3:0] off_v [8] = '{4'h0, 4'h9, 4'h6, 4'ha, 4'h0, 4'ha, 4'h0, 4'ha};
      int n_on, n_off, bad;
      for (int i = 0; i < 8; i++) begin
         cmd_a <= hbd_cmd_t'(i);
         cmd_b <= HBD_CMD_BRAKE;
         cyc(4);
         n_on = 0;
         n_off = 0;
         bad = 0;
         repeat (300) begin
            cyc(1);
            if (fet_gate_a === on_v[i]) n_on++;
            else if (fet_gate_a === off_v[i]) n_off++;
            else bad++;
            if (fet_gate_b !== 4'ha) bad++;
         end
         check(bad, 0);
         check(n_on > 0 && (n_off > 0 || i < 4), 1);
      end
      $display("mode test done");
   endtask
   task automatic t_chop();
      int t = 0;
      int start = 0;
      int runs = 0;
      logic [3:0] g = 4'h0;
      cmd_a <= HBD_CMD_FWD;
      chop_trip <= 2'h1;
      repeat (8000) begin
         cyc(1);
         t++;
         if (fet_gate_a === 4'h9 && g !== 4'h9) begin
            if (runs > 1) check(t - start == 2500, 1);
            start = t;
            runs++;
         end
         if (fet_gate_a === 4'ha && g === 4'h9) check(t - start >= 387 && t - start <= 391, 1);
         g = fet_gate_a;
      end
      check(runs >= 3, 1);
      chop_trip <= 2'h0;
      cyc(2600);
      check(fet_gate_a, 4'h9);
      $display("chop test done");
   endtask
   task automatic t_oc();
      int n = 0;
      int rises = 0;
      logic p = 1'b0;
      cmd_b <= HBD_CMD_FWD;
      oc_a <= 4'h2;
      cyc(20);
      oc_a <= 4'h0;
      cyc(4);
      check({bridge_shutdown, fet_gate_a}, 6'h09);
      oc_a <= 4'h2;
      while (bridge_shutdown[0] !== 1'b1 && n < 60) begin
         cyc(1);
         n++;
      end
      check(n >= 22 && n <= 25, 1);
      oc_a <= 4'h0;
      cyc(3);
      check({fault_seen, hbd_if_i.fault_flag_out_n, fet_gate_a, fet_gate_b}, 10'h209);
      n = 0;
      while (bridge_shutdown[0] !== 1'b0 && n < 200) begin
         cyc(1);
         n++;
      end
      check(n >= RETRY - 6 && n <= RETRY + 2, 1);
      cyc(4);
      check({fault_seen, hbd_if_i.fault_flag_out_n, fet_gate_a}, 6'h19);
      oc_a <= 4'h1;
      repeat (3 * RETRY + 90) begin
         cyc(1);
         if (bridge_shutdown[0] === 1'b1 && !p) rises++;
         p = bridge_shutdown[0];
      end
      check(rises >= 2, 1);
      oc_a <= 4'h0;
      oc_b <= 4'h8;
      cyc(RETRY + 10);
      check({bridge_shutdown, fet_gate_a}, 6'h29);
      oc_b <= 4'h0;
      cyc(RETRY + 10);
      $display("overcurrent test done");
   endtask
   task automatic t_thermal();
      hot <= 1'b1;
      cyc(3);
      check({hbd_if_i.fault_flag_out_n, fet_gate_a, fet_gate_b}, 9'h100);
      hot <= 1'b0;
      cyc(3);
      check(fet_gate_a, 4'h9);
      low_sup <= 1'b1;
      cyc(3);
      check({hbd_if_i.fault_flag_out_n, charge_pump_en, fet_gate_a}, 6'h00);
      low_sup <= 1'b0;
      cyc(6);
      check({hbd_if_i.fault_flag_out_n, fet_gate_a}, 5'h19);
      $display("thermal and lockout test done");
   endtask
   task automatic t_sleep();
      sleep_req <= 1'b1;
      cyc(4);
      check({hbd_if_i.low_power_request_n, charge_pump_en, ready, fet_gate_a, fet_gate_b}, 11'h000);
      do_reset();
      t_wake();
      cyc(4);
      check(fet_gate_a, 4'h9);
      $display("sleep test done");
   endtask
   initial begin
      do_reset();
      t_wake();
      t_modes();
      t_chop();
      t_oc();
      t_thermal();
      t_sleep();
      end_of_test();
   end
endmodule
